// [hw/steer_consts.svh]
`ifndef STEER_CONSTS_SVH
`define STEER_CONSTS_SVH
// Word layout: data plus check bits
`define WORD_W 76
`define DATA_W 64
`define CHECK_W 12
// One write packet: 32 data bits then 6 check bits
`define PKT_W 38
// Arriving address, split at the slice boundary
`define ADDR_IN_W 25
`define ADDR_LOW_MSB 11
`define ADDR_HIGH_LSB 12
// Low address bits used for steering and stripped before word select
`define ADDR_DROP 4
`define WORD_SEL_W 21
// Destination code buried in the data field of a read
`define DEST_W 14
// Relay occupancy limit and holding-buffer depth
`define SLICE_ENTRIES 6
`define RELAY_DEPTH 8
// Reference type codes
`define RT_ABORT 4'h0
`define RT_READ 4'h1
`define RT_PWRITE 4'h2
`define RT_SETBAD 4'h4
`define RT_RDBAD 4'h6
`define RT_IOW_BIT 3
`endif

// [hw/steer_pkg.sv]
`include "steer_consts.svh"
package steer_pkg;
   // Control group sent in the cycle after valid
   typedef struct packed {
      logic write_ref;
      logic [3:0] ref_type;
      logic [2:0] bank;
      logic [3:0] subsection;
   } ctrl_type;
   // One assembled reference as held in the relay
   typedef struct packed {
      ctrl_type ctrl;
      logic [`WORD_SEL_W-1:0] word_sel;
      logic [`WORD_W-1:0] word;
   } ref_type;
   // Stack-side strobes and steering
   typedef struct packed {
      logic cs;
      logic we;
      logic upper;
      logic [1:0] pair;
      logic [3:0] subsection;
      logic [`WORD_SEL_W-1:0] addr;
      logic [`WORD_W-1:0] wdata;
   } stack_type;
   typedef enum logic [2:0] {
      ACC_ABORT, ACC_READ, ACC_PWRITE, ACC_SETBAD, ACC_RDBAD, ACC_IOWRITE, ACC_INVALID
   } access_type;
   typedef enum logic [1:0] {
      ASM_IDLE, ASM_CTRL, ASM_LOW, ASM_HIGH
   } asm_state_type;
endpackage : steer_pkg

// [hw/relay_fifo.sv]
`timescale 1ns/1ps
module relay_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   input wire logic out_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   // Occupancy
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [$clog2(DEPTH+1)-1:0] next_level;
   logic push, pop;

   // Honest full and empty from the occupancy count
   assign in_ready = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign out_valid = (level != '0);
   assign out_data = mem[rd_ptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointer wrap handles non-power-of-two depths
   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_level = level;
      if (push) begin
         next_wr_ptr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == AW'(DEPTH - 1)) ? '0 : AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
         next_level = level + 1'b1;
      end else if (pop && !push) begin
         next_level = level - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         level <= next_level;
      end
   end

   // Storage carries no reset; only entries counted by level are read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule : relay_fifo

// [hw/memory_module_write_steering.sv]
`timescale 1ns/1ps
`include "steer_consts.svh"
// Operation
// (R1) Odd slice takes address bits 0-11, even slice bits 12-24.
// (R2) Bank controller word select is 21 remaining address bits.
// (R3) Each stage drops address bits no longer needed for word select.
// (R4) Requester sends valid, then control, then address and data.
// (R5) A memory word is 76 bits: 64 data plus 12 check bits.
// (R6) Write bit 1 means two packets; 0 means read, one 76-bit packet.
// (R7) First write packet holds lower bits, second holds upper bits.
// (R8) A 4-bit reference type travels with every reference to the controller.
// (R9) Type decode: abort, read, write, set/read bad bit, I/O write, invalid.
// (R10) During writes only bank bit 2 picks upper or lower banks.
// (R11) Bank bits dropped; a forced 2-bit return path names the source.
// (R12) Return path bits acknowledge arrival back to the source processor.
// (R13) Eight bank multiplexers serve each group of four processors.
// (R14) Sixteen bank controllers serve each group of four processors.
// (R15) Controller drives chip select, write enable, clock; write needs both.
// (R16) Stack clock is a replica of the module clock.
// (R17) Requester sends low slice bits one period, high slice next period.
// (R18) Each input slice forwards write data to four bank multiplexers.
// (R19) Multiplexer makes a spare bit to route around a bad chip.
// (R20) Lower half moves via two slices, eight muxes, four controllers.
// (R21) Subsection bits pass through unchanged and do not steer.
// (R22) Read: requester sends valid then control; module steers to stack.
// (R23) Read data returns to the requester with a destination code.
// (R24) Slice relay holds six references, accepting while an entry is free.
// (R25) Multiplexer holds four references while its output is busy.
// (R26) Arbitration first-come first-served, last grant gets lowest priority.
// (R27) Controller queues write references in a four-entry buffer.
// (R28) Invalid reference type never asserts write enable.
// (R29) Controller holds first packet until second, then drives full word.
module memory_module_write_steering #(
   parameter logic [1:0] PATH_CODE = 2'h0,
   parameter int RELAY_DEPTH = `RELAY_DEPTH,
   parameter int SLICE_ENTRIES = `SLICE_ENTRIES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Request from the access path
   input wire logic req_valid,
   output logic req_ready,
   input wire steer_pkg::ctrl_type req_ctrl,
   input wire logic [`ADDR_IN_W-1:0] req_addr,
   input wire logic [`WORD_W-1:0] req_pkt,
   // Spare chip configuration
   input wire logic spare_enable,
   // Memory stack
   input wire logic stack_ready,
   output steer_pkg::stack_type stack,
   output logic stack_clk,
   output logic spare_route_bit,
   input wire logic stack_rvalid,
   input wire logic [`WORD_W-1:0] stack_rdata,
   // Status back to the processor
   output logic ref_ack,
   output logic [1:0] return_path,
   output logic ref_type_err,
   output logic rsp_valid,
   output logic [`WORD_W-1:0] rsp_data,
   output logic [`DEST_W-1:0] rsp_dest
);
   localparam int LW = $clog2(RELAY_DEPTH + 1);

   steer_pkg::asm_state_type state, next_state;
   steer_pkg::ref_type asm_ref, next_asm_ref;
   steer_pkg::ref_type head;
   steer_pkg::access_type acc;
   steer_pkg::stack_type next_stack;
   logic [LW-1:0] level;
   logic fifo_in_ready, fifo_out_valid, push, pop;
   logic next_ack, next_err, next_spare;
   logic [`DEST_W-1:0] dest, next_dest;
   logic next_rsp_valid;
   logic [`WORD_W-1:0] next_rsp_data;
   logic [`DEST_W-1:0] next_rsp_dest;

   // Accept a new reference only from idle and while a relay entry is free
   assign req_ready = (state == steer_pkg::ASM_IDLE) && fifo_in_ready
      && (level < LW'(SLICE_ENTRIES)); // R24
   assign push = ((state == steer_pkg::ASM_LOW) && !asm_ref.ctrl.write_ref)
      || (state == steer_pkg::ASM_HIGH);

   // Assembly: valid, control, low/address packet, then high packet on writes
   always_comb begin
      next_state = state;
      next_asm_ref = asm_ref;
      unique case (state)
         steer_pkg::ASM_IDLE: begin
            if (req_valid && req_ready) begin
               next_state = steer_pkg::ASM_CTRL; // R4 R22
            end
         end
         steer_pkg::ASM_CTRL: begin
            next_asm_ref.ctrl = req_ctrl; // R8 R21
            next_state = steer_pkg::ASM_LOW;
         end
         steer_pkg::ASM_LOW: begin
            // Both slices' halves meet, then low steering bits are stripped
            next_asm_ref.word_sel = req_addr[`ADDR_IN_W-1:`ADDR_DROP]; // R1 R2 R3
            if (asm_ref.ctrl.write_ref) begin
               next_asm_ref.word[31:0] = req_pkt[31:0]; // R7 R17
               next_asm_ref.word[69:64] = req_pkt[`PKT_W-1:32];
               next_state = steer_pkg::ASM_HIGH; // R6
            end else begin
               next_asm_ref.word = req_pkt; // R6 R5
               next_state = steer_pkg::ASM_IDLE;
            end
         end
         steer_pkg::ASM_HIGH: begin
            next_asm_ref.word[63:32] = req_pkt[31:0]; // R7 R17
            next_asm_ref.word[75:70] = req_pkt[`PKT_W-1:32];
            next_state = steer_pkg::ASM_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= steer_pkg::ASM_IDLE;
         asm_ref <= '0;
      end else begin
         state <= next_state;
         asm_ref <= next_asm_ref;
      end
   end

   // Pushed word carries the high packet merged in this cycle
   steer_pkg::ref_type push_ref;
   always_comb begin
      push_ref = next_asm_ref;
   end

   // Relay: one queue stands for slice, multiplexer and controller buffering;
   // with a single source there is no contention, so order of arrival wins
   relay_fifo #(
      .WIDTH($bits(steer_pkg::ref_type)),
      .DEPTH(RELAY_DEPTH)
   ) u_relay (
      .clk(clk),
      .arst_n(arst_n),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_ref),
      .out_ready(stack_ready),
      .out_valid(fifo_out_valid),
      .out_data(head),
      .level(level)
   ); // R24 R25 R26 R27 R29

   assign pop = fifo_out_valid && stack_ready;

   // Reference type decode; the top bit alone marks an I/O write
   always_comb begin
      if (head.ctrl.ref_type[`RT_IOW_BIT]) begin
         acc = steer_pkg::ACC_IOWRITE; // R9
      end else begin
         unique case (head.ctrl.ref_type)
            `RT_ABORT: acc = steer_pkg::ACC_ABORT;
            `RT_READ: acc = steer_pkg::ACC_READ;
            `RT_PWRITE: acc = steer_pkg::ACC_PWRITE;
            `RT_SETBAD: acc = steer_pkg::ACC_SETBAD;
            `RT_RDBAD: acc = steer_pkg::ACC_RDBAD;
            default: acc = steer_pkg::ACC_INVALID; // R9
         endcase
      end
   end

   // Bank controller: strobes, steering and return path per popped reference
   always_comb begin
      next_stack = stack;
      next_stack.cs = 1'b0;
      next_stack.we = 1'b0;
      next_ack = 1'b0;
      next_err = 1'b0;
      next_spare = spare_route_bit;
      next_dest = dest;
      if (pop) begin
         next_stack.upper = head.ctrl.bank[2]; // R10
         next_stack.pair = head.ctrl.bank[1:0]; // R13 R14 R20
         next_stack.subsection = head.ctrl.subsection; // R21
         next_stack.addr = head.word_sel; // R2
         next_stack.wdata = head.word; // R18 R29
         next_spare = spare_enable; // R19
         next_err = (acc == steer_pkg::ACC_INVALID);
         // Abort and invalid codes touch nothing in the stack
         next_stack.cs = (acc != steer_pkg::ACC_ABORT)
            && (acc != steer_pkg::ACC_INVALID); // R15
         next_stack.we = head.ctrl.write_ref && ((acc == steer_pkg::ACC_PWRITE)
            || (acc == steer_pkg::ACC_IOWRITE) || (acc == steer_pkg::ACC_SETBAD)); // R15 R28
         next_ack = (acc != steer_pkg::ACC_INVALID); // R12
         if (!head.ctrl.write_ref) begin
            next_dest = head.word[`DEST_W-1:0]; // R23
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stack <= '0;
         ref_ack <= 1'b0;
         ref_type_err <= 1'b0;
         spare_route_bit <= 1'b0;
         dest <= '0;
      end else begin
         stack <= next_stack;
         ref_ack <= next_ack;
         ref_type_err <= next_err;
         spare_route_bit <= next_spare;
         dest <= next_dest;
      end
   end

   // Forced return path names this source; bank bits are not forwarded
   assign return_path = PATH_CODE; // R11

   // Stack clock is the module clock passed straight through
   assign stack_clk = clk; // R16

   // Read return: one outstanding code; a newer read overwrites it
   always_comb begin
      next_rsp_valid = stack_rvalid;
      next_rsp_data = rsp_data;
      next_rsp_dest = rsp_dest;
      if (stack_rvalid) begin
         next_rsp_data = stack_rdata; // R23
         next_rsp_dest = dest;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_valid <= 1'b0;
         rsp_data <= '0;
         rsp_dest <= '0;
      end else begin
         rsp_valid <= next_rsp_valid;
         rsp_data <= next_rsp_data;
         rsp_dest <= next_rsp_dest;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   property p_write_needs_both;
      stack.we |-> stack.cs;
   endproperty
   a_write_needs_both: assert property (p_write_needs_both) // R15
      else $error("write enable without chip select");

   property p_invalid_no_we;
      pop && (acc == steer_pkg::ACC_INVALID) |=> !stack.we && !stack.cs && ref_type_err;
   endproperty
   a_invalid_no_we: assert property (p_invalid_no_we) // R28
      else $error("invalid type reached the stack");

   property p_upper_from_bank2;
      pop |=> stack.upper == $past(head.ctrl.bank[2]);
   endproperty
   a_upper_from_bank2: assert property (p_upper_from_bank2) // R10
      else $error("bank group not taken from bank bit 2");

   property p_word_sel;
      pop |=> stack.addr == $past(head.word_sel) && stack.subsection == $past(head.ctrl.subsection);
   endproperty
   a_word_sel: assert property (p_word_sel) // R2
      else $error("word select or subsection changed");

   property p_write_two_packets;
      state == steer_pkg::ASM_LOW && asm_ref.ctrl.write_ref |=> state == steer_pkg::ASM_HIGH
         ##1 state == steer_pkg::ASM_IDLE;
   endproperty
   a_write_two_packets: assert property (p_write_two_packets) // R6
      else $error("write did not take two packets");

   property p_read_one_packet;
      state == steer_pkg::ASM_LOW && !asm_ref.ctrl.write_ref |-> push ##1 state == steer_pkg::ASM_IDLE;
   endproperty
   a_read_one_packet: assert property (p_read_one_packet) // R6
      else $error("read did not take one packet");

   // Acceptance is gated before the push, so the count itself must stay in bounds
   property p_relay_limit;
      level <= LW'(SLICE_ENTRIES);
   endproperty
   a_relay_limit: assert property (p_relay_limit) // R24
      else $error("relay holds more references than allowed");

   property p_ack_on_valid;
      pop && (acc == steer_pkg::ACC_READ) |=> ref_ack && stack.cs && !stack.we;
   endproperty
   a_ack_on_valid: assert property (p_ack_on_valid) // R12
      else $error("read reference not acknowledged");

   property p_high_packet;
      state == steer_pkg::ASM_HIGH |-> push && push_ref.word[63:32] == req_pkt[31:0]
         && push_ref.word[31:0] == $past(req_pkt[31:0]);
   endproperty
   a_high_packet: assert property (p_high_packet) // R7
      else $error("upper packet misplaced");

   property p_rsp_dest;
      stack_rvalid |=> rsp_valid && rsp_dest == $past(dest);
   endproperty
   a_rsp_dest: assert property (p_rsp_dest) // R23
      else $error("read return lost its destination code");

   c_write: cover property (stack.we);
   c_read_return: cover property (rsp_valid);
   c_invalid: cover property (ref_type_err);
   c_full: cover property (!req_ready && state == steer_pkg::ASM_IDLE);
endmodule : memory_module_write_steering

// [verif/ref_requester.sv]
`timescale 1ns/1ps
`include "steer_consts.svh"
// Access-path model: issues one reference at a time in valid, control, address order
module ref_requester (
   // Clock
   input wire logic clk,
   // Request side of the block
   input wire logic req_ready,
   output logic req_valid,
   output steer_pkg::ctrl_type req_ctrl,
   output logic [`ADDR_IN_W-1:0] req_addr,
   output logic [`WORD_W-1:0] req_pkt
);
   // Idle values at time zero
   initial begin
      req_valid = 1'b0;
      req_ctrl = '0;
      req_addr = '0;
      req_pkt = '0;
   end

   // One reference; ok is low when the block never became ready
   task automatic send(input steer_pkg::ctrl_type c, input logic [`ADDR_IN_W-1:0] a,
      input logic [`WORD_W-1:0] w, output bit ok);
      int n;
      n = 0;
      @(posedge clk);
      #2;
      while (req_ready !== 1'b1 && n < 100) begin
         @(posedge clk);
         #2;
         n++;
      end
      ok = (n < 100);
      if (ok) begin
         req_valid = 1'b1;
         @(posedge clk);
         #2;
         req_valid = 1'b0;
         req_ctrl = c;
         @(posedge clk);
         #2;
         // Stale control is inverted so a late sample cannot match
         req_ctrl = ~c;
         req_addr = a;
         req_pkt = c.write_ref ? {~w[75:38], w[69:64], w[31:0]} : w;
         if (c.write_ref) begin
            @(posedge clk);
            #2;
            req_addr = ~a;
            req_pkt = {~w[75:38], w[75:70], w[63:32]};
         end
         @(posedge clk);
         #2;
         req_addr = ~a;
         req_pkt = ~w;
      end
   endtask : send
endmodule : ref_requester

// [verif/memory_module_write_steering_tb.sv]
`timescale 1ns/1ps
`include "steer_consts.svh"
module memory_module_write_steering_tb;
   // Bench signals
   logic clk, arst_n, req_valid, req_ready, spare_enable, stack_ready, stack_clk;
   logic spare_route_bit, stack_rvalid, ref_ack, ref_type_err, rsp_valid;
   steer_pkg::ctrl_type req_ctrl, c;
   steer_pkg::stack_type stack, s;
   logic [`ADDR_IN_W-1:0] req_addr, a;
   logic [`WORD_W-1:0] req_pkt, stack_rdata, rsp_data, w;
   logic [`DEST_W-1:0] rsp_dest;
   logic [1:0] return_path;
   logic [3:0] f;
   bit ok;
   logic sp;
   int acc;
   int error_cnt = 0;
   int total_checks = 0;
   steer_pkg::stack_type seen_q[$];
   logic [3:0] flag_q[$];
   logic spare_q[$];

   memory_module_write_steering #(.PATH_CODE(2'h2)) dut_u (
      .clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req_ctrl(req_ctrl), .req_addr(req_addr), .req_pkt(req_pkt),
      .spare_enable(spare_enable), .stack_ready(stack_ready), .stack(stack),
      .stack_clk(stack_clk), .spare_route_bit(spare_route_bit),
      .stack_rvalid(stack_rvalid), .stack_rdata(stack_rdata), .ref_ack(ref_ack),
      .return_path(return_path), .ref_type_err(ref_type_err), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_dest(rsp_dest));

   ref_requester req_u (
      .clk(clk), .req_ready(req_ready), .req_valid(req_valid), .req_ctrl(req_ctrl),
      .req_addr(req_addr), .req_pkt(req_pkt));

   // 20 MHz clock
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Strobes last one cycle, so sample them mid-cycle
   always @(negedge clk) begin
      if (stack.cs | ref_ack | ref_type_err) begin
         seen_q.push_back(stack);
         flag_q.push_back({stack.cs, stack.we, ref_ack, ref_type_err});
         spare_q.push_back(spare_route_bit);
      end
   end

   task automatic chk(input logic [`WORD_W-1:0] sv, ev, input string m);
      total_checks++;
      if (sv !== ev) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, m);
      end
   endtask : chk

   // Waits a bounded time for a stack event, then takes it
   task automatic take_ev();
      int k;
      k = 0;
      while (flag_q.size() == 0 && k < 200) begin
         @(posedge clk);
         k++;
      end
      chk(76'(flag_q.size() != 0), 76'h1, "stack event missing");
      f = (flag_q.size() != 0) ? flag_q.pop_front() : 4'h0;
      s = (seen_q.size() != 0) ? seen_q.pop_front() : '0;
      sp = (spare_q.size() != 0) ? spare_q.pop_front() : 1'b0;
   endtask : take_ev

   // Expected {cs, we, ack, err} for a reference
   function automatic logic [3:0] exp_flags(input logic wr, input logic [3:0] t);
      if (t == 4'h3 || t == 4'h5 || t == 4'h7) return 4'h1;
      if (t == 4'h0) return 4'h2;
      return {1'b1, wr & (t == 4'h2 || t == 4'h4 || t[3]), 2'h2};
   endfunction : exp_flags

   task results;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   // Watchdog well beyond the expected run length
   initial begin
      #(50 * 20000);
      error_cnt++;
      results();
   end

   // Main sequence
   initial begin
      arst_n = 1'b0;
      spare_enable = 1'b1;
      stack_ready = 1'b1;
      stack_rvalid = 1'b0;
      stack_rdata = '0;
      repeat (10) @(posedge clk);
      chk(76'(req_ready), 76'h1, "ready in reset");
      #2;
      arst_n = 1'b1;
      // Every type code, strobes checked; steering checked when cs is set, word when we is set
      for (int t = 0; t < 16; t++) begin
         c.write_ref = !(t == 1 || t == 6);
         c.ref_type = 4'(t);
         c.bank = 3'(t);
         c.subsection = 4'(15 - t);
         a = {21'h15a5a ^ 21'(t << 9), 4'(t)};
         w = {12'(t * 5 + 1), 64'h0123456789abcdef ^ 64'(t)};
         req_u.send(c, a, w, ok);
         take_ev();
         chk(76'(f), 76'(exp_flags(c.write_ref, c.ref_type)), "strobes");
         if (f[3]) begin
            chk(76'(s.addr), 76'(a[24:4]), "word select");
            chk(76'({s.upper, s.pair}), 76'(c.bank), "bank steer");
            chk(76'(s.subsection), 76'(c.subsection), "subsection");
            chk(76'(sp), 76'h1, "spare bit");
         end
         if (f[2])
            chk(s.wdata, w, "write word");
      end
      chk(76'(return_path), 76'h2, "return path");
      // Sample away from the edge so the pass-through has settled
      #2;
      chk(76'(stack_clk), 76'h1, "stack clock high");
      @(negedge clk);
      #2;
      chk(76'(stack_clk), 76'h0, "stack clock low");
      $display("test type decode done");
      // Read reference and its return with the destination code
      c = '0;
      c.ref_type = `RT_READ;
      c.bank = 3'h5;
      req_u.send(c, 25'h1f0e0d3, {62'h2aaa_5555_0f0f_3c3, 14'h2a5c}, ok);
      take_ev();
      chk(76'(f), 76'ha, "read strobes");
      @(posedge clk);
      #2;
      stack_rvalid = 1'b1;
      stack_rdata = 76'h9_8765_4321_0fed_cba9;
      @(posedge clk);
      #2;
      stack_rvalid = 1'b0;
      stack_rdata = ~stack_rdata;
      chk(76'(rsp_valid), 76'h1, "return valid");
      chk(rsp_data, 76'h9_8765_4321_0fed_cba9, "return data");
      chk(76'(rsp_dest), 76'h2a5c, "destination code");
      @(posedge clk);
      #2;
      chk(76'(rsp_valid), 76'h0, "return one cycle");
      $display("test read return done");
      // Stall the stack until the relay refuses, then drain in order
      stack_ready = 1'b0;
      spare_enable = 1'b0;
      acc = 0;
      c.write_ref = 1'b1;
      c.ref_type = `RT_PWRITE;
      for (int k = 0; k < 7; k++) begin
         req_u.send(c, 25'(k << 4), {12'(k), 64'(k) * 64'h1111}, ok);
         acc += int'(ok);
      end
      chk(76'(acc), 76'd6, "relay entries");
      chk(76'(flag_q.size()), 76'h0, "no write while stalled");
      stack_ready = 1'b1;
      for (int k = 0; k < 6; k++) begin
         take_ev();
         chk(s.wdata, {12'(k), 64'(k) * 64'h1111}, "drain order");
         chk(76'(s.addr), 76'(k), "drain address");
         chk(76'(sp), 76'h0, "spare off per reference");
      end
      chk(76'(spare_route_bit), 76'h0, "spare off");
      $display("test relay fill done");
      results();
   end
endmodule : memory_module_write_steering_tb
